// ---- bench/pid_loop_props.sv ----
// Checker on the PID loop core ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module pid_loop_props
	import pid_loop_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [31:0] rd_data_out,
	input wire logic reading_strobe_in,
	input wire logic signed [15:0] reading_in,
	input wire logic signed [15:0] nom_min_in,
	input wire logic signed [15:0] nom_max_in,
	input wire logic interlock_in,
	input wire logic signed [15:0] out_pct_out,
	input wire logic update_done_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);
	// Cycles since the last strobe; saturates so a done with no strobe shows
	logic [7:0] since;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			since <= 8'hff;
		end else if (reading_strobe_in) begin
			since <= 8'h00;
		end else if (since != 8'hff) begin
			since <= since + 8'h01;
		end
	end
	property p_rd_idle;
		!$past(rd_en_in) |-> rd_data_out == 32'h0000_0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
	property p_hold;
		!update_done_out |-> $stable(out_pct_out);
	endproperty
	a_hold: assert property (p_hold) else $error("output moved between updates");
	property p_done_one;
		update_done_out |=> !update_done_out [*8];
	endproperty
	a_done_one: assert property (p_done_one) else $error("done pulse repeated");
	property p_latency;
		update_done_out |-> since >= 8'h64 && since <= 8'hc8;
	endproperty
	a_latency: assert property (p_latency) else $error("done not tied to a strobe");
	property p_clamp;
		update_done_out |-> out_pct_out >= 16'sh0000 && out_pct_out <= 16'sh6400;
	endproperty
	a_clamp: assert property (p_clamp) else $error("output beyond limits");
	property p_rst_quiet;
		!$past(arst_n_in) |-> out_pct_out == 16'sh0000 && !update_done_out;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
	property p_unmapped;
		rd_en_in && addr_in == 8'hfc |=> rd_data_out == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rst_bit;
		rd_en_in && addr_in == ADDR_CTRL |=> !rd_data_out[CTRL_RST_BIT];
	endproperty
	a_rst_bit: assert property (p_rst_bit) else $error("reset command bit reads set");
endmodule
bind pid_loop_core pid_loop_props #(.TICK_CYCLES(TICK_CYCLES)) props (
	.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
	.wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
	.reading_strobe_in(reading_strobe_in), .reading_in(reading_in), .nom_min_in(nom_min_in),
	.nom_max_in(nom_max_in), .interlock_in(interlock_in), .out_pct_out(out_pct_out),
	.update_done_out(update_done_out)
);

// ---- bench/sensor_actuator_model.sv ----
// Sensor and actuator side: issues readings and records each output update.
// Assumes the bench asks for a reading with a one-cycle go pulse.
`timescale 1ns/1ps
module sensor_actuator_model (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic go_in,
	input wire logic signed [15:0] value_in,
	input wire logic signed [15:0] out_pct_in,
	input wire logic update_done_in,
	output logic reading_strobe_out,
	output logic signed [15:0] reading_out,
	output logic signed [15:0] last_pct_out,
	output logic [7:0] n_updates_out
);
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reading_strobe_out <= 1'b0;
			reading_out <= 16'sh0000;
		end else begin
			reading_strobe_out <= go_in;
			// Line toggles off the strobe so a late sample is caught
			reading_out <= go_in ? value_in : ~reading_out;
		end
	end
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			last_pct_out <= 16'sh0000;
			n_updates_out <= 8'h00;
		end else if (update_done_in) begin
			last_pct_out <= out_pct_in;
			n_updates_out <= n_updates_out + 8'h01;
		end
	end
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the PID loop core.
// Assumes a short tick parameter so reading intervals stay small.
`timescale 1ns/1ps
module testbench;
	import pid_loop_pkg::*;
	typedef struct {
		logic [15:0] ctrl;
		logic [15:0] sp;
		logic [15:0] umax;
		logic [15:0] gain;
		logic [15:0] pv;
		logic [15:0] exp;
		logic [15:0] slack;
	} row_s;
	localparam logic signed [31:0] ZERO = 32'sh0000_0000;
	localparam logic signed [31:0] TOP = 32'sh7fff_ffff;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0000_0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic interlock = 1'b0;
	logic go = 1'b0;
	logic signed [15:0] value = 16'sh0000;
	logic [31:0] rd_data_out;
	logic reading_strobe;
	logic signed [15:0] reading;
	logic signed [15:0] out_pct_out;
	logic signed [15:0] last_pct;
	logic update_done_out;
	logic [7:0] n_upd;
	logic [7:0] n0;
	logic [31:0] d;
	logic [31:0] a1;
	int n_fail = 0;
	int checks = 0;
	logic [7:0] ra [6] = '{ADDR_CTRL, ADDR_OUT_MIN, ADDR_OUT_MAX, ADDR_GAIN_P, ADDR_INT_TIME, 8'hfc};
	logic [15:0] rv [6] = '{16'h0000, OUT_MIN_RST, OUT_MAX_RST, GAIN_P_RST, INT_TIME_RST, 16'h0000};
	// Row order matters: the Hand row is last so no later row sees a preset
	row_s rows [9] = '{
		'{16'h0006, 16'h01f4, 16'h0000, 16'h0100, 16'h00fa, 16'h1900, 16'h0000},
		'{16'h000e, 16'h01f4, 16'h0000, 16'h0100, 16'h02ee, 16'h1900, 16'h0000},
		'{16'h000e, 16'h01f4, 16'h0000, 16'h0100, 16'h00fa, 16'h0000, 16'h0000},
		'{16'h0006, 16'h01f4, 16'h0000, 16'h0200, 16'h00fa, 16'h3200, 16'h0000},
		'{16'h0006, 16'h03e8, 16'h0000, 16'h0200, 16'h0000, 16'h6400, 16'h0000},
		'{16'h0016, 16'h01f4, 16'h07d0, 16'h0100, 16'h00fa, 16'h0c80, 16'h0000},
		'{16'h0002, 16'h01f4, 16'h0000, 16'h0200, 16'h00fa, 16'h3200, 16'h0010},
		'{16'h0000, 16'h01f4, 16'h0000, 16'h0100, 16'h00fa, 16'h0000, 16'h0000},
		'{16'h0001, 16'h01f4, 16'h0000, 16'h0100, 16'h00fa, 16'h1234, 16'h0000}
	};
	pid_loop_core #(.TICK_CYCLES(10)) dut (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr), .wr_data_in(wr_data),
		.wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data_out),
		.reading_strobe_in(reading_strobe), .reading_in(reading), .nom_min_in(16'sh0000),
		.nom_max_in(16'sh03e8), .interlock_in(interlock), .out_pct_out(out_pct_out),
		.update_done_out(update_done_out)
	);
	sensor_actuator_model model (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .go_in(go), .value_in(value),
		.out_pct_in(out_pct_out), .update_done_in(update_done_out),
		.reading_strobe_out(reading_strobe), .reading_out(reading), .last_pct_out(last_pct),
		.n_updates_out(n_upd)
	);
	initial begin
		forever #10 clk_in = ~clk_in;
	end
	task automatic close_out;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic signed [31:0] lo,
		input logic signed [31:0] hi, input logic signed [31:0] got);
		checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_fail++;
			$display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		addr <= a;
		wr_data <= {16'h0000, v};
		wr_en <= 1'b1;
		@(posedge clk_in);
		wr_en <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_in);
		rd_en <= 1'b0;
		#1;
		v = rd_data_out;
		@(posedge clk_in);
	endtask
	task automatic upd(input logic [15:0] pv);
		value <= pv;
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		for (int k = 0; k < 300 && update_done_out !== 1'b1; k++) begin
			@(posedge clk_in);
			#1;
		end
		cmp("done", 1, 1, {31'h0000_0000, update_done_out});
		repeat (40) @(posedge clk_in);
	endtask
	initial begin
		#(20 * 20000);
		n_fail++;
		$display("mismatch watchdog expected finish seen hang");
		close_out;
	end
	initial begin
		repeat (12) @(posedge clk_in);
		arst_n_in <= 1'b1;
		cmp("out rst", ZERO, ZERO, out_pct_out);
		for (int i = 0; i < 6; i++) begin
			rd(ra[i], d);
			cmp("reset reg", {16'h0000, rv[i]}, {16'h0000, rv[i]}, d);
		end
		$display("test reset values done");
		wr(ADDR_INT_TIME, 16'hffff);
		wr(ADDR_HAND, 16'h1234);
		for (int i = 0; i < 9; i++) begin
			wr(ADDR_SETPT, rows[i].sp);
			wr(ADDR_IN_MAX, rows[i].umax);
			wr(ADDR_GAIN_P, rows[i].gain);
			wr(ADDR_CTRL, rows[i].ctrl | 16'h0100);
			upd(rows[i].pv);
			cmp("row out", rows[i].exp, rows[i].exp + rows[i].slack, out_pct_out);
		end
		$display("test rows done");
		wr(ADDR_GAIN_P, 16'h0100);
		wr(ADDR_CTRL, 16'h0104);
		upd(16'h00fa);
		rd(ADDR_AREA, d);
		cmp("area off", ZERO, ZERO, d);
		wr(ADDR_CTRL, 16'h0006);
		interlock <= 1'b1;
		upd(16'h00fa);
		cmp("out ilk", ZERO, ZERO, out_pct_out);
		rd(ADDR_AREA, d);
		cmp("area ilk", ZERO, ZERO, d);
		interlock <= 1'b0;
		upd(16'h00fa);
		rd(ADDR_AREA, a1);
		cmp("area run", 1, TOP, a1);
		wr(ADDR_CTRL, 16'h0004);
		upd(16'h00fa);
		rd(ADDR_AREA, d);
		cmp("area hold", a1, a1, d);
		wr(ADDR_CTRL, 16'h0006);
		upd(16'h00fa);
		rd(ADDR_AREA, d);
		cmp("area resume", a1 + 1, TOP, d);
		$display("test integral hold done");
		wr(ADDR_GAIN_P, 16'h0200);
		wr(ADDR_SETPT, 16'h03e8);
		wr(ADDR_CTRL, 16'h0106);
		upd(16'h0000);
		cmp("out max", 32'sh0000_6400, 32'sh0000_6400, out_pct_out);
		rd(ADDR_AREA, d);
		cmp("area windup", ZERO, ZERO, d);
		$display("test windup done");
		wr(ADDR_GAIN_P, 16'h0100);
		wr(ADDR_GAIN_I, 16'h0100);
		wr(ADDR_GAIN_D, 16'h0300);
		wr(ADDR_HAND, 16'h2000);
		wr(ADDR_SETPT, 16'h01f4);
		wr(ADDR_CTRL, 16'h0105);
		upd(16'h0000);
		wr(ADDR_CTRL, 16'h0006);
		upd(16'h00fa);
		cmp("out preset", 32'sh0000_2000, 32'sh0000_2000, out_pct_out);
		rd(ADDR_AREA, d);
		cmp("area preset", 32'sh001b_5800, 32'sh001b_5800, d);
		$display("test bumpless done");
		// Interval is about 16 ticks; bounds cover 15 to 18 so phase cannot trip it
		wr(ADDR_GAIN_D, 16'h0010);
		upd(16'h0000);
		cmp("out deriv", 32'sh0000_4ff8, 32'sh0000_5490, out_pct_out);
		$display("test derivative done");
		wr(ADDR_CTRL, 16'h0000);
		n0 = n_upd;
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		repeat (4) @(posedge clk_in);
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		repeat (400) @(posedge clk_in);
		cmp("updates", n0 + 8'h01, n0 + 8'h01, n_upd);
		cmp("last out", ZERO, ZERO, last_pct);
		$display("test busy strobe done");
		close_out;
	end
endmodule

// ---- src/pid_loop_core.sv ----
// PID control core: one update per sensor reading taken while idle, register port for setup.
// Assumes reading strobe and nominal range come from logic on clk_in;
// the interlock level arrives from a pin and is synchronised here.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module pid_loop_core
	import pid_loop_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [31:0] rd_data_out,
	input wire logic reading_strobe_in,
	input wire logic signed [15:0] reading_in,
	input wire logic signed [15:0] nom_min_in,
	input wire logic signed [15:0] nom_max_in,
	input wire logic interlock_in,
	output logic signed [15:0] out_pct_out,
	output logic update_done_out
);

	function automatic logic signed [31:0] sat32(input logic signed [63:0] v);
		if (v > 64'sh0000_0000_7fff_ffff) begin
			return 32'sh7fff_ffff;
		end else if (v < 64'shffff_ffff_8000_0000) begin
			return 32'sh8000_0000;
		end
		return v[31:0];
	endfunction

	function automatic logic signed [15:0] sat16(input logic signed [63:0] v);
		if (v > 64'sh0000_0000_0000_7fff) begin
			return 16'sh7fff;
		end else if (v < 64'shffff_ffff_ffff_8000) begin
			return 16'sh8000;
		end
		return v[15:0];
	endfunction

	function automatic logic [63:0] mag64(input logic signed [63:0] v);
		return v[63] ? 64'(-v) : 64'(v);
	endfunction

	function automatic logic signed [63:0] ugain(input logic [15:0] g);
		return 64'($signed({1'b0, g}));
	endfunction

	// Configuration
	logic [1:0] hand_off_auto_mode;
	logic gain_form;
	logic direction;
	logic use_user_range;
	logic reset_cmd;
	logic signed [15:0] set_point;
	logic signed [15:0] user_min;
	logic signed [15:0] user_max;
	logic [15:0] gain_p;
	logic [15:0] integ_time;
	logic [15:0] gain_i;
	logic [15:0] deriv_time;
	logic [15:0] gain_d;
	logic signed [15:0] out_min;
	logic signed [15:0] out_max;
	logic signed [15:0] hand_pct;

	// Algorithm state
	pid_state_e state;
	logic signed [15:0] err;
	logic signed [15:0] prev_err;
	logic signed [63:0] error_difference;
	logic signed [31:0] area;
	logic signed [31:0] cand_area;
	logic signed [31:0] iq;
	logic signed [31:0] dq;
	logic [15:0] dt_lat;
	logic [15:0] dt_ms;
	logic first;
	logic bump_pend;
	logic [1:0] mode_prev;
	logic ilk_meta;
	logic ilk_sync;
	logic [15:0] tick_cnt;
	logic tick;

	// Divider
	logic div_start;
	logic signed [NW-1:0] div_num;
	logic signed [DW-1:0] div_den;
	logic [NW-1:0] dv_quo;
	logic [DW:0] dv_rem;
	logic [DW-1:0] dv_den;
	logic [DW:0] dv_shift;
	logic [6:0] dv_cnt;
	logic dv_neg;
	logic dv_zero;
	logic dv_busy;
	logic div_done;
	logic signed [63:0] div_q;
	logic [63:0] num_mag;
	logic [63:0] den_mag;

	// Combinational helpers
	logic signed [63:0] range_lo;
	logic signed [63:0] range_hi;
	logic signed [63:0] diff_now;
	logic signed [15:0] e_now;
	logic signed [63:0] de_now;
	logic signed [63:0] inc_now;
	logic signed [31:0] cand_now;
	logic signed [63:0] raw;
	logic signed [15:0] clamped;
	logic signed [31:0] preset;
	logic accum_en;
	logic hand_to_auto;
	logic take;
	logic [31:0] rd_word;

	// Register writes
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hand_off_auto_mode <= MODE_RST;
			gain_form <= FORM_STANDARD;
			direction <= 1'h0;
			use_user_range <= 1'h0;
			reset_cmd <= 1'h0;
			set_point <= SETPT_RST;
			user_min <= IN_RANGE_RST;
			user_max <= IN_RANGE_RST;
			gain_p <= GAIN_P_RST;
			integ_time <= INT_TIME_RST;
			gain_i <= GAIN_I_RST;
			deriv_time <= DER_TIME_RST;
			gain_d <= GAIN_D_RST;
			out_min <= OUT_MIN_RST;
			out_max <= OUT_MAX_RST;
			hand_pct <= HAND_RST;
		end else begin
			reset_cmd <= 1'h0;
			if (wr_en_in) begin
				unique case (addr_in)
					ADDR_CTRL: begin
						hand_off_auto_mode <= wr_data_in[CTRL_MODE_LSB +: 2];
						gain_form <= wr_data_in[CTRL_FORM_BIT];
						direction <= wr_data_in[CTRL_DIR_BIT];
						use_user_range <= wr_data_in[CTRL_RANGE_BIT];
						reset_cmd <= wr_data_in[CTRL_RST_BIT];
					end
					ADDR_SETPT: set_point <= wr_data_in[15:0];
					ADDR_IN_MIN: user_min <= wr_data_in[15:0];
					ADDR_IN_MAX: user_max <= wr_data_in[15:0];
					ADDR_GAIN_P: gain_p <= wr_data_in[15:0];
					ADDR_INT_TIME: integ_time <= wr_data_in[15:0];
					ADDR_GAIN_I: gain_i <= wr_data_in[15:0];
					ADDR_DER_TIME: deriv_time <= wr_data_in[15:0];
					ADDR_GAIN_D: gain_d <= wr_data_in[15:0];
					ADDR_OUT_MIN: out_min <= wr_data_in[15:0];
					ADDR_OUT_MAX: out_max <= wr_data_in[15:0];
					ADDR_HAND: hand_pct <= wr_data_in[15:0];
					default: ;
				endcase
			end
		end
	end

	// Register reads; unmapped addresses read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (addr_in)
			ADDR_CTRL: begin
				rd_word[CTRL_MODE_LSB +: 2] = hand_off_auto_mode;
				rd_word[CTRL_FORM_BIT] = gain_form;
				rd_word[CTRL_DIR_BIT] = direction;
				rd_word[CTRL_RANGE_BIT] = use_user_range;
			end
			ADDR_SETPT: rd_word = 32'(set_point);
			ADDR_IN_MIN: rd_word = 32'(user_min);
			ADDR_IN_MAX: rd_word = 32'(user_max);
			ADDR_GAIN_P: rd_word = 32'(gain_p);
			ADDR_INT_TIME: rd_word = 32'(integ_time);
			ADDR_GAIN_I: rd_word = 32'(gain_i);
			ADDR_DER_TIME: rd_word = 32'(deriv_time);
			ADDR_GAIN_D: rd_word = 32'(gain_d);
			ADDR_OUT_MIN: rd_word = 32'(out_min);
			ADDR_OUT_MAX: rd_word = 32'(out_max);
			ADDR_HAND: rd_word = 32'(hand_pct);
			ADDR_STATUS: begin
				rd_word[15:0] = out_pct_out;
				rd_word[ST_BUSY_BIT] = (state != S_IDLE);
				rd_word[ST_ILK_BIT] = ilk_sync;
				rd_word[ST_MODE_LSB +: 2] = hand_off_auto_mode;
				rd_word[ST_FIRST_BIT] = first;
			end
			ADDR_AREA: rd_word = area;
			ADDR_ERROR: rd_word = 32'(err);
			default: ;
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_data_out <= 32'h0000_0000;
		end else begin
			rd_data_out <= rd_en_in ? rd_word : 32'h0000_0000;
		end
	end

	// Interlock pin synchroniser
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ilk_meta <= 1'h0;
			ilk_sync <= 1'h0;
		end else begin
			ilk_meta <= interlock_in;
			ilk_sync <= ilk_meta;
		end
	end

	// Millisecond tick and reading interval
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tick_cnt <= 16'h0000;
			tick <= 1'h0;
		end else begin
			tick <= (tick_cnt == 16'(TICK_CYCLES - 1));
			tick_cnt <= (tick_cnt == 16'(TICK_CYCLES - 1)) ? 16'h0000 : tick_cnt + 16'h0001;
		end
	end

	assign take = reading_strobe_in && (state == S_IDLE);

	// Saturates rather than wraps so a long gap gives a large, not tiny, dt
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dt_ms <= 16'h0000;
		end else if (take) begin
			dt_ms <= 16'h0000;
		end else if (tick && dt_ms != 16'hffff) begin
			dt_ms <= dt_ms + 16'h0001;
		end
	end

	// Mode edge tracking
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mode_prev <= MODE_RST;
		end else begin
			mode_prev <= hand_off_auto_mode;
		end
	end

	// Sequential signed divider; a zero divisor gives a zero quotient
	assign dv_shift = {dv_rem[DW-1:0], dv_quo[NW-1]};
	assign num_mag = mag64(64'(div_num));
	assign den_mag = mag64(64'(div_den));

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dv_quo <= '0;
			dv_rem <= '0;
			dv_den <= '0;
			dv_cnt <= 7'h00;
			dv_neg <= 1'h0;
			dv_zero <= 1'h0;
			dv_busy <= 1'h0;
			div_done <= 1'h0;
		end else begin
			div_done <= 1'h0;
			if (div_start) begin
				dv_quo <= num_mag[NW-1:0];
				dv_rem <= '0;
				dv_den <= den_mag[DW-1:0];
				dv_cnt <= 7'(NW);
				dv_neg <= div_num[NW-1] ^ div_den[DW-1];
				dv_zero <= (div_den == '0);
				dv_busy <= 1'h1;
			end else if (dv_busy) begin
				if (dv_shift >= {1'b0, dv_den}) begin
					dv_rem <= dv_shift - {1'b0, dv_den};
					dv_quo <= {dv_quo[NW-2:0], 1'b1};
				end else begin
					dv_rem <= dv_shift;
					dv_quo <= {dv_quo[NW-2:0], 1'b0};
				end
				dv_cnt <= dv_cnt - 7'h01;
				if (dv_cnt == 7'h01) begin
					dv_busy <= 1'h0;
					div_done <= 1'h1;
				end
			end
		end
	end

	always_comb begin
		if (dv_zero) begin
			div_q = 64'sh0000_0000_0000_0000;
		end else if (dv_neg) begin
			div_q = -$signed(64'(dv_quo));
		end else begin
			div_q = $signed(64'(dv_quo));
		end
	end

	// Arithmetic of one update
	always_comb begin
		range_lo = use_user_range ? 64'(user_min) : 64'(nom_min_in);
		range_hi = use_user_range ? 64'(user_max) : 64'(nom_max_in);
		diff_now = direction ? 64'(reading_in) - 64'(set_point)
			: 64'(set_point) - 64'(reading_in);
		e_now = sat16(div_q);
		de_now = first ? 64'sh0000_0000_0000_0000 : 64'(e_now) - 64'(prev_err);
		accum_en = (hand_off_auto_mode == MODE_AUTO) && !ilk_sync && !bump_pend;
		inc_now = accum_en ? 64'(e_now) * ugain(dt_lat) : 64'sh0000_0000_0000_0000;
		cand_now = sat32(64'(area) + inc_now);
		if (gain_form == FORM_STANDARD) begin
			raw = (ugain(gain_p) * (64'(err) + 64'(iq) + 64'(dq))) >>> GAIN_FRAC;
			preset = sat32((64'(iq) - 64'(err)) * ugain(integ_time));
		end else begin
			raw = ((ugain(gain_p) * 64'(err)) >>> GAIN_FRAC) + 64'(iq) + 64'(dq);
			preset = iq;
		end
		if (raw > 64'(out_max)) begin
			clamped = out_max;
		end else if (raw < 64'(out_min)) begin
			clamped = out_min;
		end else begin
			clamped = raw[15:0];
		end
		hand_to_auto = (mode_prev == MODE_HAND) && (hand_off_auto_mode == MODE_AUTO);
	end

	// Update sequence
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= S_IDLE;
			err <= 16'h0000;
			prev_err <= 16'h0000;
			error_difference <= 64'sh0000_0000_0000_0000;
			area <= 32'h0000_0000;
			cand_area <= 32'h0000_0000;
			iq <= 32'h0000_0000;
			dq <= 32'h0000_0000;
			dt_lat <= 16'h0000;
			first <= 1'h1;
			bump_pend <= 1'h0;
			out_pct_out <= 16'h0000;
			update_done_out <= 1'h0;
			div_start <= 1'h0;
			div_num <= '0;
			div_den <= '0;
		end else begin
			div_start <= 1'h0;
			update_done_out <= 1'h0;
			unique case (state)
				S_IDLE: begin
					if (take) begin
						dt_lat <= dt_ms;
						div_num <= NW'(diff_now * 64'(PCT_SCALE));
						div_den <= DW'(range_hi - range_lo);
						div_start <= 1'h1;
						state <= S_NORM;
					end
				end
				S_NORM: begin
					if (div_done) begin
						err <= e_now;
						error_difference <= de_now;
						cand_area <= cand_now;
						div_start <= 1'h1;
						state <= S_INTG;
						if (bump_pend && gain_form == FORM_STANDARD) begin
							div_num <= NW'(64'(hand_pct) <<< GAIN_FRAC);
							div_den <= DW'(ugain(gain_p));
						end else if (bump_pend) begin
							div_num <= NW'((64'(hand_pct)
								- ((ugain(gain_p) * 64'(e_now)) >>> GAIN_FRAC))
								* 64'(INT_SCALE));
							div_den <= DW'(ugain(gain_i));
						end else if (gain_form == FORM_STANDARD) begin
							div_num <= NW'(cand_now);
							div_den <= DW'(ugain(integ_time));
						end else begin
							div_num <= NW'(64'(cand_now) * ugain(gain_i));
							div_den <= DW'(INT_SCALE);
						end
					end
				end
				S_INTG: begin
					if (div_done) begin
						iq <= sat32(div_q);
						if (bump_pend) begin
							dq <= 32'h0000_0000;
							state <= S_SUM;
						end else begin
							div_num <= NW'((gain_form == FORM_STANDARD ? ugain(deriv_time)
								: ugain(gain_d)) * error_difference);
							div_den <= DW'(ugain(dt_lat));
							div_start <= 1'h1;
							state <= S_DERV;
						end
					end
				end
				S_DERV: begin
					if (div_done) begin
						dq <= sat32(div_q);
						state <= S_SUM;
					end
				end
				S_SUM: begin
					if (bump_pend) begin
						area <= preset;
					end else if (!((raw > 64'(out_max) && cand_area > area)
						|| (raw < 64'(out_min) && cand_area < area))) begin
						area <= cand_area;
					end
					if (hand_off_auto_mode == MODE_HAND) begin
						out_pct_out <= hand_pct;
					end else if (hand_off_auto_mode == MODE_AUTO && !ilk_sync) begin
						out_pct_out <= bump_pend ? hand_pct : clamped;
					end else begin
						out_pct_out <= 16'h0000;
					end
					prev_err <= err;
					first <= 1'h0;
					bump_pend <= 1'h0;
					update_done_out <= 1'h1;
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
			// A transition seen in the same cycle as the clear still counts
			if (hand_to_auto) begin
				bump_pend <= 1'h1;
			end
			// Aborts an update before S_SUM; one in S_SUM still sets the output and done, but a stale sum cannot refill the area
			if (reset_cmd) begin
				area <= 32'h0000_0000;
				prev_err <= 16'h0000;
				first <= 1'h1;
				state <= S_IDLE;
			end
		end
	end

endmodule

// ---- src/pid_loop_pkg.sv ----
// Constants, register map and state codes for the PID loop core.
// Assumes a single 50 MHz clock and a 32-bit word register port.
package pid_loop_pkg;

	localparam int DW = 32;
	localparam int NW = 56;
	localparam int GAIN_FRAC = 8;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SETPT = 8'h04;
	localparam logic [7:0] ADDR_IN_MIN = 8'h08;
	localparam logic [7:0] ADDR_IN_MAX = 8'h0c;
	localparam logic [7:0] ADDR_GAIN_P = 8'h10;
	localparam logic [7:0] ADDR_INT_TIME = 8'h14;
	localparam logic [7:0] ADDR_GAIN_I = 8'h18;
	localparam logic [7:0] ADDR_DER_TIME = 8'h1c;
	localparam logic [7:0] ADDR_GAIN_D = 8'h20;
	localparam logic [7:0] ADDR_OUT_MIN = 8'h24;
	localparam logic [7:0] ADDR_OUT_MAX = 8'h28;
	localparam logic [7:0] ADDR_HAND = 8'h2c;
	localparam logic [7:0] ADDR_STATUS = 8'h30;
	localparam logic [7:0] ADDR_AREA = 8'h34;
	localparam logic [7:0] ADDR_ERROR = 8'h38;

	// Control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_FORM_BIT = 2;
	localparam int CTRL_DIR_BIT = 3;
	localparam int CTRL_RANGE_BIT = 4;
	localparam int CTRL_RST_BIT = 8;

	// Status fields
	localparam int ST_BUSY_BIT = 16;
	localparam int ST_ILK_BIT = 17;
	localparam int ST_MODE_LSB = 18;
	localparam int ST_FIRST_BIT = 20;

	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_HAND = 2'h1;
	localparam logic [1:0] MODE_AUTO = 2'h2;
	localparam logic FORM_STANDARD = 1'h0;

	// Reset values; percents are in 1/256 %
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [15:0] OUT_MIN_RST = 16'h0000;
	localparam logic [15:0] OUT_MAX_RST = 16'h6400;
	localparam logic [15:0] GAIN_P_RST = 16'h0100;
	localparam logic [15:0] INT_TIME_RST = 16'h2710;
	localparam logic [15:0] GAIN_I_RST = 16'h0000;
	localparam logic [15:0] DER_TIME_RST = 16'h0000;
	localparam logic [15:0] GAIN_D_RST = 16'h0000;
	localparam logic [15:0] HAND_RST = 16'h0000;
	localparam logic [15:0] SETPT_RST = 16'h0000;
	localparam logic [15:0] IN_RANGE_RST = 16'h0000;

	// Full scale in 1/256 %, and ms-to-s times gain fraction for parallel integral
	localparam int PCT_SCALE = 25600;
	localparam int INT_SCALE = 256000;

	// Time base for the reading interval
	localparam int DT_TICK_US = 1000;
	localparam int CLK_MHZ = 50;
	localparam int TICK_CYCLES_DEF = DT_TICK_US * CLK_MHZ;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_NORM = 5'h02,
		S_INTG = 5'h04,
		S_DERV = 5'h08,
		S_SUM = 5'h10
	} pid_state_e;

endpackage
